// ==== src/ssfp_port.v ====
`timescale 1ns/1ps
`include "ssfp_map.vh"
module ssfp_port #(
  parameter AW = 24
) (
  // clock and reset
  input  wire          mclk,
  input  wire          rst_n,
  input  wire          clk_en,
  // serial pins
  input  wire          sck,
  input  wire          si,
  input  wire          ce_n,
  input  wire          hold_n,
  input  wire          wp_n,
  output reg           so_q,
  output reg           so_oe_q,
  // core status inputs
  input  wire          busy,
  input  wire          wel,
  input  wire          auto_increment_program,
  input  wire          rdy_busy_en,
  // read data source
  input  wire [7:0]    tx_data,
  input  wire          tx_status_sel,
  // status write from the command decoder
  input  wire          status_wr,
  input  wire [7:0]    status_wdata,
  // erase request
  input  wire          erase_req,
  input  wire [1:0]    erase_kind,
  input  wire [AW-1:0] erase_addr,
  // received bytes and state
  output reg  [7:0]    rx_byte_q,
  output reg           rx_valid_q,
  output reg           rx_cmd_q,
  output reg           sel_q,
  output reg           pause_q,
  output reg           frame_start_q,
  output reg           frame_end_q,
  output reg  [7:0]    status_q,
  output reg           status_rej_q,
  output reg           erase_go_q,
  output reg  [AW-1:0] erase_base_q
);
  wire [2:0] pin_s;
  wire       sck_s;
  wire       ce_n_s;
  wire       hold_n_s;
  reg        si_s1_q;
  reg        si_s2_q;
  reg        wp_s1_q;
  reg        wp_s2_q;
  reg        sck_d1_q;
  reg        ce_d1_q;
  reg  [2:0] bit_q;
  reg  [6:0] in_sh_q;
  reg  [7:0] out_sh_q;
  reg        first_q;
  reg        seen_rise_q;
  reg  [3:0] bp_q;
  reg        lock_q;
  wire       sck_rise;
  wire       sck_fall;
  wire       ce_fall;
  wire       ce_rise;
  wire       active;
  wire [7:0] status_now;
  wire [7:0] tx_src;
  reg  [AW-1:0] mask_d;

  // sck, ce_n, hold_n synchronised together
  ssfp_sync #(
    .W   (3),
    .RST (`SSFP_SYNC_RST)
  ) u_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      ({sck, ce_n, hold_n}),
    .q      (pin_s)
  );
  assign sck_s    = pin_s[2];
  assign ce_n_s   = pin_s[1];
  assign hold_n_s = pin_s[0];

  // data and protect pins, same two-stage depth keeps si aligned to sck
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else if (clk_en) begin
      si_s1_q <= si;
      si_s2_q <= si_s1_q;
      wp_s1_q <= wp_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // matches the sync chain reset, no edge seen at release
      sck_d1_q <= 1'b1;
      ce_d1_q  <= 1'b1;
    end else if (clk_en) begin
      sck_d1_q <= sck_s;
      ce_d1_q  <= ce_n_s;
    end
  end

  // edges found from samples, idle level irrelevant
  assign sck_rise = sck_s & ~sck_d1_q;
  assign sck_fall = ~sck_s & sck_d1_q;
  assign ce_fall  = ~ce_n_s & ce_d1_q;
  assign ce_rise  = ce_n_s & ~ce_d1_q;
  assign active   = sel_q & ~pause_q & ~ce_n_s;

  // busy and mode bits come live from the core
  assign status_now = {lock_q, auto_increment_program, bp_q, wel, busy};
  assign tx_src     = tx_status_sel ? status_now : tx_data;

  // selection, pause and framing
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q         <= 1'b0;
      pause_q       <= 1'b0;
      frame_start_q <= 1'b0;
      frame_end_q   <= 1'b0;
    end else if (clk_en) begin
      frame_start_q <= 1'b0;
      frame_end_q   <= 1'b0;
      if (ce_rise) begin
        // deselect while paused clears pause as well
        sel_q       <= 1'b0;
        pause_q     <= 1'b0;
        frame_end_q <= sel_q;
      end else if (ce_fall) begin
        // only a falling select opens a command
        sel_q         <= 1'b1;
        pause_q       <= 1'b0;
        frame_start_q <= 1'b1;
      end else if (sel_q && !sck_s) begin
        // hold_n changes pause only during clock-low phase
        pause_q <= ~hold_n_s;
      end
    end
  end

  // input shifter, bit counter and byte hand-off
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q       <= 3'h0;
      in_sh_q     <= 7'h00;
      rx_byte_q   <= 8'h00;
      rx_valid_q  <= 1'b0;
      rx_cmd_q    <= 1'b0;
      first_q     <= 1'b0;
      seen_rise_q <= 1'b0;
    end else if (clk_en) begin
      rx_valid_q <= 1'b0;
      if (ce_fall || ce_rise) begin
        // a partial byte is dropped on any select change
        bit_q       <= 3'h0;
        first_q     <= 1'b1;
        seen_rise_q <= 1'b0;
      end else if (active && sck_rise) begin
        seen_rise_q <= 1'b1;
        bit_q       <= bit_q + 3'h1;
        in_sh_q     <= {in_sh_q[5:0], si_s2_q};
        if (bit_q == `SSFP_BYTE_BITS) begin
          // msb arrives first; first byte marked as command
          rx_byte_q  <= {in_sh_q, si_s2_q};
          rx_valid_q <= 1'b1;
          rx_cmd_q   <= first_q;
          first_q    <= 1'b0;
        end
      end
    end
  end

  // output shifter and drive
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_q <= 8'h00;
      so_q     <= 1'b0;
      so_oe_q  <= 1'b0;
    end else if (clk_en) begin
      if (!active || ce_fall) begin
        so_oe_q <= 1'b0;
      end else if (rdy_busy_en && auto_increment_program) begin
        so_q    <= ~busy;
        so_oe_q <= 1'b1;
      end else if (sck_fall && seen_rise_q) begin
        // next bit on falling clock; mode 3 first fall skipped
        so_oe_q <= 1'b1;
        if (bit_q == 3'h0) begin
          so_q     <= tx_src[7];
          out_sh_q <= {tx_src[6:0], 1'b0};
        end else begin
          so_q     <= out_sh_q[7];
          out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // status register with lock gating
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bp_q         <= `SSFP_BP_RST;
      lock_q       <= `SSFP_LOCK_RST;
      status_q     <= 8'h00;
      status_rej_q <= 1'b0;
    end else if (clk_en) begin
      status_rej_q <= 1'b0;
      status_q     <= status_now;
      if (status_wr) begin
        // lock bit only counts while write-protect is low
        if (wp_s2_q || !lock_q) begin
          bp_q   <= status_wdata[`SSFP_ST_BP_HI:`SSFP_ST_BP_LO];
          lock_q <= status_wdata[`SSFP_ST_LOCK];
        end else begin
          status_rej_q <= 1'b1;
        end
      end
    end
  end

  always @* begin
    case (erase_kind)
      `SSFP_ER_SECTOR: mask_d = {AW{1'b1}} << `SSFP_SH_SECTOR;
      `SSFP_ER_BLK32:  mask_d = {AW{1'b1}} << `SSFP_SH_BLK32;
      `SSFP_ER_BLK64:  mask_d = {AW{1'b1}} << `SSFP_SH_BLK64;
      default:         mask_d = {AW{1'b0}};
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      erase_go_q   <= 1'b0;
      erase_base_q <= {AW{1'b0}};
    end else if (clk_en) begin
      // unknown kind refused and base zeroed; other kinds force base to their boundary
      erase_go_q <= erase_req && (erase_kind != 2'h3);
      if (erase_req) begin
        erase_base_q <= erase_addr & mask_d;
      end
    end
  end
endmodule // ssfp_port

// ==== src/ssfp_map.vh ====
`ifndef SSFP_MAP_VH
`define SSFP_MAP_VH

// status byte field positions
`define SSFP_ST_BUSY      0
`define SSFP_ST_WEL       1
`define SSFP_ST_BP_LO     2
`define SSFP_ST_BP_HI     5
`define SSFP_ST_INC       6
`define SSFP_ST_LOCK      7

// status reset values
`define SSFP_BP_RST       4'h7
`define SSFP_LOCK_RST     1'h0

// erase kinds and their alignment shifts
`define SSFP_ER_SECTOR    2'h0
`define SSFP_ER_BLK32     2'h1
`define SSFP_ER_BLK64     2'h2
`define SSFP_SH_SECTOR    12
`define SSFP_SH_BLK32     15
`define SSFP_SH_BLK64     16

// serial framing
`define SSFP_BYTE_BITS    3'h7
`define SSFP_SYNC_RST     3'h7

`endif

// ==== src/ssfp_sync.v ====
`timescale 1ns/1ps
module ssfp_sync #(
  parameter       W   = 3,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rst_n,
  input  wire         clk_en,
  // pins in, synchronised out
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // first stage feeds the second only
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[i] <= RST[i];
          s2_q[i] <= RST[i];
        end else if (clk_en) begin
          s1_q[i] <= d[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate

  assign q = s2_q;
endmodule // ssfp_sync

// ==== testbench/ssfp_monitor.sv ====
`timescale 1ns/1ps
module ssfp_monitor #(
  parameter AW = 24
) (
  // clock and reset
  input wire          mclk,
  input wire          rst_n,
  // pins and core inputs
  input wire          ce_n,
  input wire          wp_n,
  input wire          busy,
  input wire          auto_increment_program,
  input wire          rdy_busy_en,
  input wire          status_wr,
  input wire [7:0]    status_wdata,
  input wire          erase_req,
  input wire [1:0]    erase_kind,
  input wire [AW-1:0] erase_addr,
  // outputs
  input wire          so_q,
  input wire          so_oe_q,
  input wire          sel_q,
  input wire          pause_q,
  input wire          frame_start_q,
  input wire          frame_end_q,
  input wire [7:0]    status_q,
  input wire          status_rej_q,
  input wire          erase_go_q,
  input wire [AW-1:0] erase_base_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire [AW-1:0] emask = {AW{1'b1}} << (erase_kind == 2'h0 ? 12 : erase_kind == 2'h1 ? 15 : 16);
  wire          rb_on = sel_q & ~pause_q & rdy_busy_en & auto_increment_program;
  // wp_n needs three samples to clear its sync chain
  sequence s_lock_wr;
    !wp_n [*3] ##0 status_wr && status_q[7];
  endsequence
  sequence s_free_wr;
    wp_n [*3] ##0 status_wr;
  endsequence
  AST_WR_OK: assert property (s_free_wr |=> !status_rej_q ##1
    {status_q[7], status_q[5:2]} == $past({status_wdata[7], status_wdata[5:2]}, 2))
    else $error("status write lost");
  AST_WR_REJ: assert property (s_lock_wr |=> status_rej_q ##1
    status_q[5:2] == $past(status_q[5:2], 2)) else $error("locked write taken");
  AST_BUSY: assert property (status_q[0] == $past(busy)) else $error("busy bit wrong");
  AST_ERASE: assert property (erase_req && erase_kind != 2'h3 |=> erase_go_q &&
    erase_base_q == $past(erase_addr & emask)) else $error("erase base wrong");
  AST_ERASE_BAD: assert property (erase_req && erase_kind == 2'h3 |=> !erase_go_q)
    else $error("bad erase kind taken");
  AST_DESEL_OE: assert property (ce_n [*4] |-> !so_oe_q) else $error("driven deselected");
  AST_PAUSE_OE: assert property (pause_q [*2] |-> !so_oe_q) else $error("driven paused");
  AST_PAUSE_SEL: assert property ($rose(pause_q) |-> sel_q) else $error("pause deselects");
  AST_DESEL: assert property (ce_n [*4] |-> !sel_q && !pause_q) else $error("no deselect");
  AST_START: assert property ($rose(sel_q) |-> frame_start_q) else $error("no frame start");
  AST_END: assert property ($fell(sel_q) |-> frame_end_q) else $error("no frame end");
  AST_RDY: assert property (rb_on [*2] |-> so_oe_q && so_q == !$past(busy))
    else $error("ready busy wrong");
endmodule // ssfp_monitor
bind ssfp_port ssfp_monitor #(.AW(AW)) u_mon (.*);

// ==== testbench/ssfp_host.sv ====
`timescale 1ns/1ps
module ssfp_host (
  // serial pins
  output reg  sck,
  output reg  si,
  output reg  ce_n,
  input  wire so
);
  reg mode3 = 1'b0;
  initial begin
    sck = 1'b0;
    si = 1'b0;
    ce_n = 1'b1;
  end
  task start;
    begin
      sck = mode3;
      #100;
      ce_n = 1'b0;
      #100;
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sck = 1'b0;
        si = tx[i];
        #100;
        sck = 1'b1;
        rx[i] = so;
        #100;
      end
    end
  endtask
  // released data line flips so stale bits never pass
  task stop;
    begin
      sck = mode3;
      #100;
      ce_n = 1'b1;
      si = ~si;
      #100;
    end
  endtask
endmodule // ssfp_host

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         hold_n = 1'b1;
  reg         wp_n = 1'b1;
  reg         busy = 1'b0;
  reg         inc_mode = 1'b0;
  reg         wel_r = 1'b0;
  reg         st_sel = 1'b0;
  reg         rb_en = 1'b0;
  reg  [7:0]  tx_data = 8'h00;
  reg         st_wr = 1'b0;
  reg  [7:0]  st_wd = 8'h00;
  reg         er_req = 1'b0;
  reg  [1:0]  er_kind = 2'h0;
  reg  [7:0]  rx, last_rx;
  reg         last_cmd;
  integer     err_count = 0;
  integer     n_tests = 0;
  integer     k;
  wire        sck, si, ce_n, so_q, so_oe_q, rx_valid_q, rx_cmd_q, sel_q, pause_q;
  wire        status_rej_q, erase_go_q;
  wire [7:0]  rx_byte_q, status_q;
  wire [23:0] erase_base_q;
  ssfp_host host (.sck(sck), .si(si), .ce_n(ce_n), .so(so_oe_q ? so_q : ~so_q));
  ssfp_port dut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .sck(sck), .si(si), .ce_n(ce_n),
    .hold_n(hold_n), .wp_n(wp_n), .so_q(so_q), .so_oe_q(so_oe_q), .busy(busy), .wel(wel_r),
    .auto_increment_program(inc_mode), .rdy_busy_en(rb_en), .tx_data(tx_data),
    .tx_status_sel(st_sel), .status_wr(st_wr), .status_wdata(st_wd), .erase_req(er_req),
    .erase_kind(er_kind), .erase_addr(24'habcdef), .rx_byte_q(rx_byte_q),
    .rx_valid_q(rx_valid_q), .rx_cmd_q(rx_cmd_q), .sel_q(sel_q), .pause_q(pause_q),
    .frame_start_q(), .frame_end_q(), .status_q(status_q), .status_rej_q(status_rej_q),
    .erase_go_q(erase_go_q), .erase_base_q(erase_base_q));
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (rx_valid_q) begin
    last_rx <= rx_byte_q;
    last_cmd <= rx_cmd_q;
  end
  task check(input [23:0] got, input [23:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        err_count = err_count + 1;
      end
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task wr_st(input [7:0] d, input rej, input [7:0] st);
    begin
      @(negedge mclk) st_wr = 1'b1;
      st_wd = d;
      @(negedge mclk) check(status_rej_q, rej);
      st_wr = 1'b0;
      @(negedge mclk) check(status_q, st);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    wait_n(10);
    rst_n = 1'b1;
    @(negedge mclk) check(status_q, 8'h1c);
    for (k = 0; k < 2; k = k + 1) begin
      host.mode3 = k;
      tx_data = 8'h3c ^ k;
      host.start;
      host.xfer(8'ha5, rx);
      check({last_cmd, last_rx}, 9'h1a5);
      host.xfer(8'h5a, rx);
      check(rx, 8'h3c ^ k);
      check({last_cmd, last_rx, so_oe_q}, 10'h0b5);
      host.stop;
      wait_n(3);
      check(so_oe_q, 1'b0);
    end
    $display("test end: modes");
    host.mode3 = 1'b0;
    host.start;
    host.xfer(8'hc3, rx);
    hold_n = 1'b0;
    wait_n(8);
    check(pause_q, 1'b0);
    host.sck = 1'b0;
    wait_n(8);
    check({pause_q, sel_q, so_oe_q}, 3'h6);
    hold_n = 1'b1;
    wait_n(8);
    host.xfer(8'h96, rx);
    check(last_rx, 8'h96);
    host.ce_n = 1'b1;
    wait_n(8);
    host.start;
    hold_n = 1'b0;
    wait_n(8);
    check(pause_q, 1'b1);
    host.ce_n = 1'b1;
    wait_n(8);
    check({sel_q, pause_q}, 2'h0);
    hold_n = 1'b1;
    $display("test end: pause");
    inc_mode = 1'b1;
    rb_en = 1'b1;
    busy = 1'b1;
    host.start;
    wait_n(6);
    check({so_oe_q, so_q, status_q[0]}, 3'h5);
    busy = 1'b0;
    wait_n(2);
    check({so_oe_q, so_q, status_q[0]}, 3'h6);
    host.stop;
    inc_mode = 1'b0;
    $display("test end: ready busy");
    wr_st(8'h80, 1'b0, 8'h80);
    wp_n = 1'b0;
    wait_n(3);
    wr_st(8'h3c, 1'b1, 8'h80);
    wp_n = 1'b1;
    wait_n(3);
    wr_st(8'h00, 1'b0, 8'h00);
    $display("test end: protect");
    wel_r = 1'b1;
    st_sel = 1'b1;
    busy = 1'b1;
    host.start;
    host.xfer(8'h05, rx);
    host.xfer(8'h00, rx);
    check(rx, 8'h03);
    busy = 1'b0;
    host.xfer(8'h00, rx);
    check(rx, 8'h02);
    host.stop;
    st_sel = 1'b0;
    wel_r = 1'b0;
    $display("test end: status read");
    for (k = 0; k < 4; k = k + 1) begin
      @(negedge mclk) er_kind = k;
      er_req = 1'b1;
      @(negedge mclk) er_req = 1'b0;
      check(erase_go_q, k != 3);
      if (k != 3)
        check(erase_base_q, k == 0 ? 24'habc000 : k == 1 ? 24'hab8000 : 24'hab0000);
    end
    $display("test end: erase");
    complete_run;
  end
endmodule // tb_top
